// ### rtl/uts_top.sv
// Test control of a serial port with infrared encoder, on AXI4-Lite.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "uts_cfg.svh"
module uts_top (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Write address channel
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // Write data channel
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // Write response channel
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // Read address channel
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // Read data channel
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Infrared path
  input wire logic SIR_TX_ACTIVE,
  output logic SIR_RX_ENABLE,
  // Clock enables towards the serial core
  output logic TEST_CLK_EN,
  output logic BAUD16_EN,
  output logic LOWPOWER16_EN
);

  // ----------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------

  function automatic logic is_pulse(input logic [7:0] addr);
    is_pulse = (addr >= `UTS_PULSE_LO) && (addr <= `UTS_PULSE_HI);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = is_pulse(addr);
    hit = hit || (addr == `UTS_BDIV_ADDR);
    hit = hit || (addr == `UTS_LDIV_ADDR);
    hit = hit || (addr == `UTS_STAT_ADDR);
    hit = hit || (addr == `UTS_TCC_ADDR);
    hit = hit || (addr == `UTS_TMS_ADDR);
    is_mapped = hit;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  uts_pkg::uts_top_t q;
  uts_pkg::uts_top_t next_q;
  logic tcken;
  logic baud_tick;
  logic lp_tick;
  logic baud_cnt_en;
  logic lp_cnt_en;
  logic [15:0] baud_count;
  logic [7:0] lp_count;
  logic [31:0] rd_word;
  logic [7:0] rd_addr;
  logic wr_fire;
  logic wr_lane0;
  logic wr_lane1;

  // Protection bits carry no meaning for these registers.
  logic unused_prot;
  assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT, baud_count, lp_count};

  // ----------------------------------------------------------------------
  // Test clock enable
  // ----------------------------------------------------------------------

  uts_tcken u_tcken (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .test_en(q.tcc[`UTS_TCC_TEST_EN]),
    .clk_src(q.tcc[`UTS_TCC_CLK_SRC]),
    .clk_mode(q.tcc[`UTS_TCC_CLK_MODE]),
    .access(q.access),
    .access_hit(q.access_hit),
    .tcken(tcken)
  );

  // ----------------------------------------------------------------------
  // Baud and low-power counters
  // ----------------------------------------------------------------------

  // With bypass the baud counter freezes and the enable is used directly.
  assign baud_cnt_en = tcken && !q.tms[`UTS_TMS_BYPASS];
  assign lp_cnt_en = tcken;

  uts_downcnt #(
    .WIDTH(16),
    .STEP_NIB(`UTS_BAUD_STEP_NIB),
    .STEP_ONE(`UTS_BAUD_STEP_ONE)
  ) u_baud_cnt (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .en(baud_cnt_en),
    .nibble(q.tms[`UTS_TMS_BAUD_NIB]),
    .reload(q.bdiv),
    .count(baud_count),
    .tick(baud_tick)
  );

  uts_downcnt #(
    .WIDTH(8),
    .STEP_NIB(`UTS_LP_STEP_NIB),
    .STEP_ONE(`UTS_LP_STEP_ONE)
  ) u_lp_cnt (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .en(lp_cnt_en),
    .nibble(q.tms[`UTS_TMS_LP_NIB]),
    .reload(q.ldiv),
    .count(lp_count),
    .tick(lp_tick)
  );

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------

  // A write is performed once both halves are held and no answer waits.
  // Holding the response back keeps one write in flight at a time.
  assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
  assign wr_lane0 = wr_fire && q.wstrb[0];
  assign wr_lane1 = wr_fire && q.wstrb[1];

  // ----------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------

  // The address is looked at only at the edge that takes it, so the live
  // bus value is enough and no address register is spent here.
  assign rd_addr = S_AXI_ARADDR;

  always_comb begin
    rd_word = 32'h00000000;
    case (rd_addr)
      `UTS_BDIV_ADDR: begin
        rd_word[15:0] = q.bdiv;
      end
      `UTS_LDIV_ADDR: begin
        rd_word[7:0] = q.ldiv;
      end
      `UTS_STAT_ADDR: begin
        rd_word[`UTS_STAT_TCKEN] = tcken;
        rd_word[`UTS_STAT_SIR_RX] = q.sir_rx_en;
        rd_word[`UTS_STAT_TEST] = q.tcc[`UTS_TCC_TEST_EN];
      end
      `UTS_TCC_ADDR: begin
        rd_word[2:0] = q.tcc;
      end
      `UTS_TMS_ADDR: begin
        // Bits above the mode field read as zero.
        rd_word[3:0] = q.tms;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  always_comb begin
    next_q = q;
    next_q.access = 1'b0;
    next_q.access_hit = 1'b0;

    // Address and data are caught independently, in either order.
    if (S_AXI_AWVALID && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.wdata = S_AXI_WDATA;
      next_q.wstrb = S_AXI_WSTRB;
    end

    // Response retires before a new write may be performed.
    if (q.bvalid && S_AXI_BREADY) begin
      next_q.bvalid = 1'b0;
    end

    if (wr_fire) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.access = 1'b1;
      next_q.access_hit = is_pulse(q.awaddr);
      if (is_mapped(q.awaddr)) begin
        next_q.bresp = `UTS_RESP_OKAY;
      end else begin
        next_q.bresp = `UTS_RESP_SLVERR;
      end
    end

    // Lane 0 carries every narrow field; lane 1 only the divisor top.
    if (wr_lane0) begin
      case (q.awaddr)
        `UTS_BDIV_ADDR: begin
          next_q.bdiv[7:0] = q.wdata[7:0];
        end
        `UTS_LDIV_ADDR: begin
          next_q.ldiv = q.wdata[7:0];
        end
        `UTS_TCC_ADDR: begin
          next_q.tcc = q.wdata[2:0];
        end
        `UTS_TMS_ADDR: begin
          next_q.tms = q.wdata[3:0];
        end
        default: begin
          next_q.tms = q.tms;
        end
      endcase
    end
    if (wr_lane1 && (q.awaddr == `UTS_BDIV_ADDR)) begin
      next_q.bdiv[15:8] = q.wdata[15:8];
    end

    // Read channel: a new address is refused while data is outstanding.
    if (q.rvalid && S_AXI_RREADY) begin
      next_q.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_word;
      next_q.access = 1'b1;
      // A write hit in the same cycle must not be lost to a read miss.
      next_q.access_hit = next_q.access_hit || is_pulse(S_AXI_ARADDR);
      if (is_mapped(S_AXI_ARADDR)) begin
        next_q.rresp = `UTS_RESP_OKAY;
      end else begin
        next_q.rresp = `UTS_RESP_SLVERR;
      end
    end

    next_q.awready = !next_q.aw_have && !next_q.bvalid;
    next_q.wready = !next_q.w_have && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;

    // The bypass gives one baud16 enable per reference enable.
    if (q.tms[`UTS_TMS_BYPASS]) begin
      next_q.baud16 = tcken;
    end else begin
      next_q.baud16 = baud_tick;
    end
    next_q.lp16 = lp_tick;

    // Receive stays open during transmit only in full-duplex test.
    next_q.sir_rx_en = !SIR_TX_ACTIVE || q.tms[`UTS_TMS_SIR_FDX];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.tcc <= `UTS_TCC_RST;
      q.tms <= `UTS_TMS_RST;
      q.bdiv <= `UTS_BDIV_RST;
      q.ldiv <= `UTS_LDIV_RST;
      q.sir_rx_en <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign SIR_RX_ENABLE = q.sir_rx_en;
  assign TEST_CLK_EN = tcken;
  assign BAUD16_EN = q.baud16;
  assign LOWPOWER16_EN = q.lp16;

endmodule // uts_top

// ### rtl/uts_cfg.svh
// Register map, field positions, reset values and counter steps.
`ifndef UTS_CFG_SVH
`define UTS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UTS_BDIV_ADDR 8'h00
`define UTS_LDIV_ADDR 8'h04
`define UTS_STAT_ADDR 8'h08
`define UTS_PULSE_LO 8'h40
`define UTS_PULSE_HI 8'h7c
`define UTS_TCC_ADDR 8'h80
`define UTS_TMS_ADDR 8'h84

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UTS_TCC_TEST_EN 0
`define UTS_TCC_CLK_SRC 1
`define UTS_TCC_CLK_MODE 2
`define UTS_TMS_BYPASS 0
`define UTS_TMS_SIR_FDX 1
`define UTS_TMS_BAUD_NIB 2
`define UTS_TMS_LP_NIB 3
`define UTS_STAT_TCKEN 0
`define UTS_STAT_SIR_RX 1
`define UTS_STAT_TEST 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UTS_TCC_RST 3'h0
`define UTS_TMS_RST 4'h0
`define UTS_BDIV_RST 16'h0010
`define UTS_LDIV_RST 8'h10

// ----------------------------------------------------------------------
// Counter decrement steps and bus answers
// ----------------------------------------------------------------------
`define UTS_BAUD_STEP_NIB 16'h1111
`define UTS_BAUD_STEP_ONE 16'h0001
`define UTS_LP_STEP_NIB 8'h11
`define UTS_LP_STEP_ONE 8'h01
`define UTS_RESP_OKAY 2'h0
`define UTS_RESP_SLVERR 2'h2

`endif

// ### rtl/uts_pkg.sv
// Types shared by the test control block.
package uts_pkg;

  typedef struct packed {
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic aw_have;
    logic w_have;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] tcc;
    logic [3:0] tms;
    logic [15:0] bdiv;
    logic [7:0] ldiv;
    logic access;
    logic access_hit;
    logic baud16;
    logic lp16;
    logic sir_rx_en;
  } uts_top_t;

endpackage

// ### rtl/uts_downcnt.sv
// Reloading down counter with a normal or nibble decrement step.
`timescale 1ns/1ps
module uts_downcnt #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] STEP_NIB = '1,
  parameter logic [WIDTH-1:0] STEP_ONE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic en,
  input wire logic nibble,
  input wire logic [WIDTH-1:0] reload,
  // Result
  output logic [WIDTH-1:0] count,
  output logic tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } uts_cnt_t;

  uts_cnt_t q;
  uts_cnt_t next_q;
  logic [WIDTH-1:0] step;

  assign step = nibble ? STEP_NIB : STEP_ONE;

  // Reaching or passing zero reloads, so a nibble step never wraps.
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (en) begin
      if (q.cnt <= step) begin
        next_q.cnt = reload;
        next_q.tick = 1'b1;
      end else begin
        next_q.cnt = q.cnt - step;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign count = q.cnt;
  assign tick = q.tick;

endmodule // uts_downcnt

// ### rtl/uts_tcken.sv
// Test clock enable generator: free running, any-access strobe or pulse-hit strobe mode.
`timescale 1ns/1ps
module uts_tcken (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode bits
  input wire logic test_en,
  input wire logic clk_src,
  input wire logic clk_mode,
  // Bus access events
  input wire logic access,
  input wire logic access_hit,
  // Enable
  output logic tcken
);

  typedef struct packed {
    logic en;
  } uts_tck_t;

  uts_tck_t q;
  uts_tck_t next_q;

  always_comb begin
    next_q = q;
    if (!(test_en && clk_src)) begin
      next_q.en = 1'b1;
    end else if (clk_mode) begin
      next_q.en = access_hit;
    end else begin
      next_q.en = access;
    end
  end

  // Free running enable is the idle state, so reset leaves it high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign tcken = q.en;

endmodule // uts_tcken

// ### verification/uts_top_asserts.sv
// Port level checks of the test control block and its bind.
`timescale 1ns/1ps
module uts_top_asserts (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  // Serial core side
  input wire logic SIR_TX_ACTIVE,
  input wire logic SIR_RX_ENABLE,
  input wire logic TEST_CLK_EN,
  input wire logic BAUD16_EN,
  input wire logic LOWPOWER16_EN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic ar_hit;
  logic wr_near;
  assign ar_hit = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_near = S_AXI_BVALID;
  a_read_answer: assert property (ar_hit |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  a_unmapped_err: assert property (ar_hit && S_AXI_ARADDR == 8'h8c
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_pulse_range: assert property (ar_hit && S_AXI_ARADDR inside
    {[8'h40:8'h7c]} |=> S_AXI_RRESP == 2'h0)
    else $error("pulse range read refused");
  a_rx_follow: assert property (!SIR_TX_ACTIVE |=> SIR_RX_ENABLE)
    else $error("receive path closed while idle");
  // Write caused pulses sit near a mode change, so only read pulses are timed.
  a_pulse_single: assert property ($rose(TEST_CLK_EN) && !wr_near &&
    !$past(wr_near) && !$past(wr_near, 2) |=> !TEST_CLK_EN)
    else $error("clock enable pulse too long");
  a_pulse_cause: assert property ($rose(TEST_CLK_EN) |-> $past(ar_hit, 2)
    || wr_near || $past(wr_near) || $past(wr_near, 2))
    else $error("clock enable without access");
  a_lp_cause: assert property ($rose(LOWPOWER16_EN)
    |-> $past(TEST_CLK_EN, 2))
    else $error("low power tick without enable");
  a_baud_cause: assert property (BAUD16_EN |-> $past(TEST_CLK_EN)
    || $past(TEST_CLK_EN, 2))
    else $error("baud tick without enable");
  c_pulse: cover property ($rose(TEST_CLK_EN));
  c_refused: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  c_duplex: cover property (SIR_TX_ACTIVE && SIR_RX_ENABLE);
endmodule // uts_top_asserts

bind uts_top uts_top_asserts uts_top_asserts_i (.SYS_CLK(SYS_CLK),
  .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .SIR_TX_ACTIVE(SIR_TX_ACTIVE), .SIR_RX_ENABLE(SIR_RX_ENABLE),
  .TEST_CLK_EN(TEST_CLK_EN), .BAUD16_EN(BAUD16_EN),
  .LOWPOWER16_EN(LOWPOWER16_EN));

// ### verification/uts_core_model.sv
// Serial core stand-in that takes the enables and drives the transmit flag.
`timescale 1ns/1ps
module uts_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench control
  input wire logic tx_go,
  // Enables from the block
  input wire logic tcken,
  input wire logic baud16,
  input wire logic lp16,
  // Towards the block and the bench
  output logic tx_active,
  output logic [31:0] cnt_tck,
  output logic [31:0] cnt_baud,
  output logic [31:0] cnt_lp
);
  // Tallies of enabled cycles let the bench judge rates over a window.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_active <= 1'b0;
      cnt_tck <= 32'h0;
      cnt_baud <= 32'h0;
      cnt_lp <= 32'h0;
    end else begin
      tx_active <= tx_go;
      cnt_tck <= cnt_tck + {31'h0, tcken};
      cnt_baud <= cnt_baud + {31'h0, baud16};
      cnt_lp <= cnt_lp + {31'h0, lp16};
    end
  end
endmodule // uts_core_model

// ### verification/uts_top_tb.sv
// Self-checking bench of the test control block.
`timescale 1ns/1ps
`include "uts_cfg.svh"
module uts_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, tx_go = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_en, tcken, b16, lp16;
  logic tx_act;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d, cnt_t, cnt_b, cnt_l, m_t, m_b, m_l, dt, db, dl;
  logic [31:0] fv [2] = '{32'h6, 32'h5};
  int fails = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  uts_top uts_top_i (.SYS_CLK(clk), .RSTN(rstn),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .SIR_TX_ACTIVE(tx_act), .SIR_RX_ENABLE(rx_en), .TEST_CLK_EN(tcken),
    .BAUD16_EN(b16), .LOWPOWER16_EN(lp16));
  uts_core_model uts_core_model_i (.clk(clk), .rstn(rstn), .tx_go(tx_go),
    .tcken(tcken), .baud16(b16), .lp16(lp16), .tx_active(tx_act),
    .cnt_tck(cnt_t), .cnt_baud(cnt_b), .cnt_lp(cnt_l));

  // --------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  task mark;
    m_t = cnt_t;
    m_b = cnt_b;
    m_l = cnt_l;
  endtask

  task diff;
    dt = cnt_t - m_t;
    db = cnt_b - m_b;
    dl = cnt_l - m_l;
  endtask

  // A window of whole tick periods holds a fixed number of ticks.
  task win(input int n);
    mark;
    repeat (n) @(posedge clk);
    diff;
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdc(`UTS_TMS_ADDR, 32'h0);
    rdc(`UTS_TCC_ADDR, 32'h0);
    rdc(`UTS_STAT_ADDR, 32'h3);
    wr(`UTS_TMS_ADDR, 32'hf);
    chk({30'h0, resp}, 32'h0);
    rdc(`UTS_TMS_ADDR, 32'hf);
    wr(`UTS_LDIV_ADDR, 32'h22);
    wr(`UTS_BDIV_ADDR, 32'h2222);
    wr(`UTS_TMS_ADDR, 32'hc);
    repeat (40) @(posedge clk);
    win(68);
    chk(db, 32'd34);
    chk(dl, 32'd34);
    wr(`UTS_BDIV_ADDR, 32'h22);
    wr(`UTS_TMS_ADDR, 32'h0);
    repeat (40) @(posedge clk);
    win(68);
    chk(db, 32'd2);
    chk(dl, 32'd2);
    wr(`UTS_TMS_ADDR, 32'h1);
    repeat (8) @(posedge clk);
    win(68);
    chk(db, 32'd68);
    wr(`UTS_TMS_ADDR, 32'h0);
    tx_go <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, rx_en}, 32'h0);
    wr(`UTS_TMS_ADDR, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_en}, 32'h1);
    tx_go <= 1'b0;
    wr(`UTS_TMS_ADDR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(`UTS_TCC_ADDR, fv[i]);
      repeat (4) @(posedge clk);
      win(68);
      chk(dt, 32'd68);
    end
    wr(`UTS_TCC_ADDR, 32'h3);
    repeat (4) @(posedge clk);
    mark;
    rd(8'h00);
    rd(8'h8c);
    chk({30'h0, resp}, 32'h2);
    wr(`UTS_LDIV_ADDR, 32'h22);
    repeat (4) @(posedge clk);
    diff;
    chk(dt, 32'd3);
    wr(`UTS_TCC_ADDR, 32'h7);
    repeat (4) @(posedge clk);
    mark;
    rd(8'h00);
    rdc(`UTS_PULSE_LO, 32'h0);
    rdc(`UTS_PULSE_HI, 32'h0);
    wr(8'h60, 32'h0);
    chk({30'h0, resp}, 32'h0);
    rdc(`UTS_TCC_ADDR, 32'h7);
    repeat (4) @(posedge clk);
    diff;
    chk(dt, 32'd3);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc(`UTS_TCC_ADDR, 32'h0);
    stop_test;
  end
endmodule // uts_top_tb
